//--- rtl/mtsp_ct_scale.sv
// Effective divisor: unity unless user scaling is on
module mtsp_ct_scale (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        scale_en,
  input  wire logic [15:0] divisor,
  output logic [15:0]      divisor_eff
);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      divisor_eff <= mtsp_pkg::CT_UNITY;
    end
    else
    begin
      divisor_eff <= scale_en ? divisor : mtsp_pkg::CT_UNITY;
    end
  end

endmodule

//--- rtl/mtsp_float_check.sv
// Positive float range test; IEEE positives order like unsigned words
module mtsp_float_check (
  input  wire logic [31:0] value,
  input  wire logic [31:0] lo,
  input  wire logic [31:0] hi,
  input  wire logic        allow_zero,
  output logic             ok
);

  logic is_zero;
  logic in_band;

  assign is_zero = (value == 32'h0000_0000);
  assign in_band = !value[31] && (value >= lo) && (value <= hi);
  assign ok      = (allow_zero && is_zero) || in_band;

endmodule

//--- rtl/mtsp_pkg.sv
package mtsp_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;
  localparam int          IDX_W          = 10;
  localparam int          IDX_LSB        = 2;
  localparam int          REG16_W        = 16;
  localparam int          NUM_CT         = 4;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [9:0]  IDX_SCALE_CTRL = 10'h04E;
  localparam logic [9:0]  IDX_COIL_TYPE  = 10'h04F;
  localparam logic [9:0]  IDX_UV_P1      = 10'h050;
  localparam logic [9:0]  IDX_UV_P2      = 10'h052;
  localparam logic [9:0]  IDX_UV_P3      = 10'h054;
  localparam logic [9:0]  IDX_COIL_FACT  = 10'h056;
  localparam logic [9:0]  IDX_CT_P1      = 10'h058;
  localparam logic [9:0]  IDX_CT_P2      = 10'h059;
  localparam logic [9:0]  IDX_CT_P3      = 10'h05A;
  localparam logic [9:0]  IDX_CT_N       = 10'h05B;
  localparam logic [9:0]  IDX_PEAK_P1    = 10'h060;
  localparam logic [9:0]  IDX_STATUS     = 10'h070;

  // ************************************************************
  // Fields, reset values, limits
  // ************************************************************
  localparam int          SCALE_BIT_LO   = 12;
  localparam logic [15:0] SCALE_MASK     = 16'hF000;
  localparam logic [15:0] SCALE_RST      = 16'h0000;
  localparam logic [31:0] UV_RST         = 32'h0000_0000;
  localparam logic [31:0] UV_MIN         = 32'h3F80_0000;
  localparam logic [31:0] UV_MAX         = 32'h43DC_0000;
  localparam logic [31:0] FLT_POS_MIN    = 32'h0000_0001;
  localparam logic [31:0] FLT_POS_MAX    = 32'h7F7F_FFFF;
  localparam logic [15:0] COIL_USER      = 16'h0000;
  localparam logic [15:0] COIL_SEL_1     = 16'h0001;
  localparam logic [15:0] COIL_SEL_2     = 16'h0002;
  localparam logic [15:0] COIL_SEL_3     = 16'h0003;
  localparam logic [15:0] COIL_TYPE_RST  = 16'h0001;
  localparam logic [31:0] COIL_F_1       = 32'h3D93_6A40;
  localparam logic [31:0] COIL_F_2       = 32'h3D93_BE23;
  localparam logic [31:0] COIL_F_3       = 32'h3D94_1744;
  localparam logic [31:0] COIL_FACT_RST  = 32'h3D93_6A40;
  localparam logic [15:0] CT_RST         = 16'h0001;
  localparam logic [15:0] CT_UNITY       = 16'h0001;
  localparam logic [15:0] CT_MIN         = 16'h0001;
  localparam logic [15:0] CT_MAX_PHASE   = 16'h09C4;
  localparam logic [15:0] CT_MAX_NEUTRAL = 16'hFFFF;
  localparam logic [15:0] PEAK_RST       = 16'h0014;
  localparam logic [15:0] PEAK_MIN       = 16'h0014;
  localparam logic [15:0] PEAK_MAX       = 16'h00FE;
  localparam int          ST_UV_LO       = 0;
  localparam int          ST_COIL_USER   = 3;
  localparam int          ST_REJECT      = 4;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;

  function automatic logic in_range16(input logic [15:0] v,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] coil_lookup(input logic [15:0] sel,
                                              input logic [31:0] user_f);
    return (sel == COIL_SEL_1) ? COIL_F_1 :
           (sel == COIL_SEL_2) ? COIL_F_2 :
           (sel == COIL_SEL_3) ? COIL_F_3 : user_f;
  endfunction

endpackage

//--- rtl/mtsp_regs.sv
module mtsp_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      uv_threshold_phase1,
  output logic [31:0]      uv_threshold_phase2,
  output logic [31:0]      uv_threshold_phase3,
  output logic [2:0]       uv_check_enable,
  output logic [31:0]      coil_factor_effective,
  output logic [15:0]      ct_divisor_eff_phase1,
  output logic [15:0]      ct_divisor_eff_phase2,
  output logic [15:0]      ct_divisor_eff_phase3,
  output logic [15:0]      ct_divisor_eff_neutral,
  output logic [15:0]      peak_interval_phase1
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [15:0] scale_ctrl;
  logic [15:0] coil_type_select;
  logic [31:0] uv_thr [3];
  logic [31:0] coil_factor_value;
  logic [15:0] ct_div [mtsp_pkg::NUM_CT];
  logic [15:0] peak_interval;
  logic        last_reject;
  logic [15:0] ct_eff [mtsp_pkg::NUM_CT];

  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  function automatic logic [31:0] reg_read(input logic [9:0] idx);
    unique case (idx)
      mtsp_pkg::IDX_SCALE_CTRL: return {16'h0000, scale_ctrl};
      mtsp_pkg::IDX_COIL_TYPE:  return {16'h0000, coil_type_select};
      mtsp_pkg::IDX_UV_P1:      return uv_thr[0];
      mtsp_pkg::IDX_UV_P2:      return uv_thr[1];
      mtsp_pkg::IDX_UV_P3:      return uv_thr[2];
      mtsp_pkg::IDX_COIL_FACT:  return coil_factor_value;
      mtsp_pkg::IDX_CT_P1:      return {16'h0000, ct_div[0]};
      mtsp_pkg::IDX_CT_P2:      return {16'h0000, ct_div[1]};
      mtsp_pkg::IDX_CT_P3:      return {16'h0000, ct_div[2]};
      mtsp_pkg::IDX_CT_N:       return {16'h0000, ct_div[3]};
      mtsp_pkg::IDX_PEAK_P1:    return {16'h0000, peak_interval};
      mtsp_pkg::IDX_STATUS:     return {27'h0000000, last_reject,
                                        (coil_type_select == mtsp_pkg::COIL_USER),
                                        uv_check_enable};
      default:                  return 32'h0000_0000;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [9:0] idx);
    return (reg_read(idx) != 32'h0000_0000) ||
           (idx == mtsp_pkg::IDX_SCALE_CTRL) || (idx == mtsp_pkg::IDX_COIL_TYPE) ||
           (idx == mtsp_pkg::IDX_UV_P1) || (idx == mtsp_pkg::IDX_UV_P2) ||
           (idx == mtsp_pkg::IDX_UV_P3) || (idx == mtsp_pkg::IDX_COIL_FACT) ||
           (idx == mtsp_pkg::IDX_CT_P1) || (idx == mtsp_pkg::IDX_CT_P2) ||
           (idx == mtsp_pkg::IDX_CT_P3) || (idx == mtsp_pkg::IDX_CT_N) ||
           (idx == mtsp_pkg::IDX_PEAK_P1) || (idx == mtsp_pkg::IDX_STATUS);
  endfunction

  // ************************************************************
  // Write channel
  // ************************************************************
  logic        aw_take;
  logic        w_take;
  logic        wr_fire;
  logic [9:0]  wr_idx;
  logic [31:0] wr_val;
  logic [15:0] wr_v16;
  logic        wr_mapped;
  logic        wr_ro;
  logic        wr_legal;
  logic        ok_uv [3];
  logic        ok_coil_f;
  logic        ok_coil_t;
  logic        ok_ct [mtsp_pkg::NUM_CT];
  logic        ok_peak;
  logic        next_aw_held;
  logic        next_w_held;
  logic        next_bvalid;

  assign aw_take   = awvalid && awready;
  assign w_take    = wvalid && wready;
  assign wr_fire   = aw_held && w_held && !bvalid;
  assign wr_idx    = aw_addr_q[mtsp_pkg::IDX_LSB +: mtsp_pkg::IDX_W];
  assign wr_val    = mtsp_pkg::merge_strb(reg_read(wr_idx), w_data_q, w_strb_q);
  assign wr_v16    = wr_val[mtsp_pkg::REG16_W-1:0];
  assign wr_mapped = is_mapped(wr_idx);
  assign wr_ro     = (wr_idx == mtsp_pkg::IDX_STATUS);

  // Zero or 1 V..440 V; anything else is refused
  for (genvar g = 0; g < 3; g++)
  begin : g_uv_chk
    mtsp_float_check u_uv_chk (
      .value      (wr_val),
      .lo         (mtsp_pkg::UV_MIN),
      .hi         (mtsp_pkg::UV_MAX),
      .allow_zero (1'b1),
      .ok         (ok_uv[g])
    );
  end

  mtsp_float_check u_coil_chk (
    .value      (wr_val),
    .lo         (mtsp_pkg::FLT_POS_MIN),
    .hi         (mtsp_pkg::FLT_POS_MAX),
    .allow_zero (1'b0),
    .ok         (ok_coil_f)
  );

  assign ok_coil_t = (wr_val[31:16] == 16'h0000) &&
                     mtsp_pkg::in_range16(wr_v16, mtsp_pkg::COIL_USER, mtsp_pkg::COIL_SEL_3);
  assign ok_peak   = (wr_val[31:16] == 16'h0000) &&
                     mtsp_pkg::in_range16(wr_v16, mtsp_pkg::PEAK_MIN, mtsp_pkg::PEAK_MAX);
  for (genvar g = 0; g < mtsp_pkg::NUM_CT; g++)
  begin : g_ct_chk
    assign ok_ct[g] = (wr_val[31:16] == 16'h0000) &&
                      mtsp_pkg::in_range16(wr_v16, mtsp_pkg::CT_MIN,
                        (g == mtsp_pkg::NUM_CT - 1) ? mtsp_pkg::CT_MAX_NEUTRAL
                                                    : mtsp_pkg::CT_MAX_PHASE);
  end

  // Reserved scaling bits just read back as zero, so that write is always legal
  assign wr_legal = (wr_idx == mtsp_pkg::IDX_UV_P1)     ? ok_uv[0]  :
                    (wr_idx == mtsp_pkg::IDX_UV_P2)     ? ok_uv[1]  :
                    (wr_idx == mtsp_pkg::IDX_UV_P3)     ? ok_uv[2]  :
                    (wr_idx == mtsp_pkg::IDX_COIL_FACT) ? ok_coil_f :
                    (wr_idx == mtsp_pkg::IDX_COIL_TYPE) ? ok_coil_t :
                    (wr_idx == mtsp_pkg::IDX_CT_P1)     ? ok_ct[0]  :
                    (wr_idx == mtsp_pkg::IDX_CT_P2)     ? ok_ct[1]  :
                    (wr_idx == mtsp_pkg::IDX_CT_P3)     ? ok_ct[2]  :
                    (wr_idx == mtsp_pkg::IDX_CT_N)      ? ok_ct[3]  :
                    (wr_idx == mtsp_pkg::IDX_PEAK_P1)   ? ok_peak   : !wr_ro;

  function automatic logic wr_hit(input logic [9:0] idx);
    return wr_fire && (wr_idx == idx) && wr_legal;
  endfunction

  assign next_aw_held = aw_take || (aw_held && !wr_fire);
  assign next_w_held  = w_take || (w_held && !wr_fire);
  assign next_bvalid  = wr_fire || (bvalid && !bready);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= mtsp_pkg::RESP_OKAY;
      awready   <= 1'b0;
      wready    <= 1'b0;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      bvalid  <= next_bvalid;
      awready <= !next_aw_held && !next_bvalid;
      wready  <= !next_w_held && !next_bvalid;
      if (aw_take)
      begin
        aw_addr_q <= awaddr;
      end
      if (w_take)
      begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire)
      begin
        bresp <= !wr_mapped ? mtsp_pkg::RESP_DECERR :
                 !wr_legal  ? mtsp_pkg::RESP_SLVERR : mtsp_pkg::RESP_OKAY;
      end
    end
  end

  // ************************************************************
  // Parameter storage
  // ************************************************************
  logic [15:0] next_scale_ctrl;
  logic [15:0] next_coil_type;
  logic [31:0] next_coil_factor;
  logic [31:0] next_uv [3];
  logic [15:0] next_ct [mtsp_pkg::NUM_CT];
  logic [15:0] next_peak;
  logic [9:0]  uv_idx [3];
  logic [9:0]  ct_idx [mtsp_pkg::NUM_CT];

  assign uv_idx[0] = mtsp_pkg::IDX_UV_P1;
  assign uv_idx[1] = mtsp_pkg::IDX_UV_P2;
  assign uv_idx[2] = mtsp_pkg::IDX_UV_P3;
  assign ct_idx[0] = mtsp_pkg::IDX_CT_P1;
  assign ct_idx[1] = mtsp_pkg::IDX_CT_P2;
  assign ct_idx[2] = mtsp_pkg::IDX_CT_P3;
  assign ct_idx[3] = mtsp_pkg::IDX_CT_N;

  assign next_scale_ctrl  = wr_hit(mtsp_pkg::IDX_SCALE_CTRL) ? (wr_v16 & mtsp_pkg::SCALE_MASK)
                                                             : scale_ctrl;
  assign next_coil_type   = wr_hit(mtsp_pkg::IDX_COIL_TYPE) ? wr_v16 : coil_type_select;
  assign next_coil_factor = wr_hit(mtsp_pkg::IDX_COIL_FACT) ? wr_val : coil_factor_value;
  assign next_peak        = wr_hit(mtsp_pkg::IDX_PEAK_P1) ? wr_v16 : peak_interval;

  for (genvar g = 0; g < 3; g++)
  begin : g_uv_next
    assign next_uv[g] = wr_hit(uv_idx[g]) ? wr_val : uv_thr[g];
  end

  for (genvar g = 0; g < mtsp_pkg::NUM_CT; g++)
  begin : g_ct
    assign next_ct[g] = wr_hit(ct_idx[g]) ? wr_v16 : ct_div[g];

    mtsp_ct_scale u_scale (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .scale_en    (next_scale_ctrl[mtsp_pkg::SCALE_BIT_LO + g]),
      .divisor     (next_ct[g]),
      .divisor_eff (ct_eff[g])
    );
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scale_ctrl            <= mtsp_pkg::SCALE_RST;
      coil_type_select      <= mtsp_pkg::COIL_TYPE_RST;
      coil_factor_value     <= mtsp_pkg::COIL_FACT_RST;
      coil_factor_effective <= mtsp_pkg::COIL_FACT_RST;
      peak_interval         <= mtsp_pkg::PEAK_RST;
      last_reject           <= 1'b0;
      uv_check_enable       <= 3'h0;
      for (int i = 0; i < 3; i++)
      begin
        uv_thr[i] <= mtsp_pkg::UV_RST;
      end
      for (int i = 0; i < mtsp_pkg::NUM_CT; i++)
      begin
        ct_div[i] <= mtsp_pkg::CT_RST;
      end
    end
    else
    begin
      scale_ctrl            <= next_scale_ctrl;
      coil_type_select      <= next_coil_type;
      coil_factor_value     <= next_coil_factor;
      coil_factor_effective <= mtsp_pkg::coil_lookup(next_coil_type, next_coil_factor);
      peak_interval         <= next_peak;
      for (int i = 0; i < 3; i++)
      begin
        uv_thr[i]          <= next_uv[i];
        uv_check_enable[i] <= (next_uv[i] != mtsp_pkg::UV_RST);
      end
      for (int i = 0; i < mtsp_pkg::NUM_CT; i++)
      begin
        ct_div[i] <= next_ct[i];
      end
      if (wr_fire && wr_mapped)
      begin
        last_reject <= !wr_legal;
      end
    end
  end

  // ************************************************************
  // Read channel
  // ************************************************************
  logic       ar_take;
  logic [9:0] rd_idx;
  logic       next_rvalid;

  assign ar_take     = arvalid && arready;
  assign rd_idx      = araddr[mtsp_pkg::IDX_LSB +: mtsp_pkg::IDX_W];
  assign next_rvalid = ar_take || (rvalid && !rready);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= mtsp_pkg::RESP_OKAY;
    end
    else
    begin
      rvalid  <= next_rvalid;
      arready <= !next_rvalid;
      if (ar_take)
      begin
        rdata <= reg_read(rd_idx);
        rresp <= is_mapped(rd_idx) ? mtsp_pkg::RESP_OKAY : mtsp_pkg::RESP_DECERR;
      end
    end
  end

  assign uv_threshold_phase1    = uv_thr[0];
  assign uv_threshold_phase2    = uv_thr[1];
  assign uv_threshold_phase3    = uv_thr[2];
  assign ct_divisor_eff_phase1  = ct_eff[0];
  assign ct_divisor_eff_phase2  = ct_eff[1];
  assign ct_divisor_eff_phase3  = ct_eff[2];
  assign ct_divisor_eff_neutral = ct_eff[3];
  assign peak_interval_phase1   = peak_interval;

  // ************************************************************
  // Checks
  // ************************************************************
  a_uv_zero_off: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> (uv_check_enable[1] == (uv_thr[1] != 32'h0000_0000)))
    else $error("undervoltage enable does not follow threshold");

  a_coil_map: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(aresetn) && coil_type_select == 16'h0002) |-> coil_factor_effective == 32'h3D93BE23)
    else $error("coil selector 2 gives wrong factor");

  a_coil_pos: assert property (@(posedge aclk) disable iff (!aresetn)
    !coil_factor_value[31] && coil_factor_value != 32'h0000_0000)
    else $error("coil factor not positive");

  a_ct_range: assert property (@(posedge aclk) disable iff (!aresetn)
    ct_div[0] >= 16'h0001 && ct_div[0] <= 16'h09C4)
    else $error("phase 1 divisor out of range");

  a_peak_range: assert property (@(posedge aclk) disable iff (!aresetn)
    peak_interval >= 16'h0014 && peak_interval <= 16'h00FE)
    else $error("peak interval out of range");

  a_scale_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> (ct_eff[2] == (scale_ctrl[14] ? ct_div[2] : 16'h0001)))
    else $error("effective divisor wrong for scaling bit");

  a_reject_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && wr_idx == 10'h060 && !ok_peak) |=> ($stable(peak_interval) ##1 bresp == 2'h2))
    else $error("illegal peak write was stored");

  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> bvalid ##0 (last_reject == !$past(wr_legal) || !$past(wr_mapped)))
    else $error("write response or reject flag wrong");

endmodule

//--- verification/test_meter_threshold_scaling_params.sv
module test_meter_threshold_scaling_params;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Signals
  // ************************************************************
  logic        aclk;
  logic        aresetn;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [31:0] uv_p1;
  logic [31:0] uv_p2;
  logic [31:0] uv_p3;
  logic [2:0]  uv_en;
  logic [31:0] coil_eff;
  logic [15:0] ct_e1;
  logic [15:0] ct_e2;
  logic [15:0] ct_e3;
  logic [15:0] ct_en;
  logic [15:0] peak;
  int          bad_count = 0;
  int          n_tests = 0;
  logic [31:0] coil_tab [4];
  logic [15:0] pk_val [4];
  logic [1:0]  pk_rsp [4];
  logic [15:0] pk_keep;

  mtsp_regs dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .uv_threshold_phase1(uv_p1), .uv_threshold_phase2(uv_p2), .uv_threshold_phase3(uv_p3),
    .uv_check_enable(uv_en), .coil_factor_effective(coil_eff),
    .ct_divisor_eff_phase1(ct_e1), .ct_divisor_eff_phase2(ct_e2),
    .ct_divisor_eff_phase3(ct_e3), .ct_divisor_eff_neutral(ct_en),
    .peak_interval_phase1(peak));

  // ************************************************************
  // Clock, verdict, compare and bus tasks
  // ************************************************************
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic end_of_test;
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s response %h want %h", $time, what, got, exp);
    end
  endtask

  // Waits are open; a dead handshake is caught by the watchdog
  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!(bvalid && bready));
    bready <= 1'b0;
    chk_resp(bresp, er, "write");
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!(rvalid && rready));
    rready <= 1'b0;
    chk_resp(rresp, er, "read");
    chk_val(rdata, ed, "read data");
  endtask

  initial
  begin
    #100us;
    bad_count++;
    end_of_test();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    aresetn = 1'b0;
    awaddr  = 12'h000;
    awvalid = 1'b0;
    wdata   = 32'h0000_0000;
    wstrb   = 4'h0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = 12'h000;
    arvalid = 1'b0;
    rready  = 1'b0;
    coil_tab = '{32'h0, mtsp_pkg::COIL_F_1, mtsp_pkg::COIL_F_2, mtsp_pkg::COIL_F_3};
    pk_val = '{16'h0013, 16'h0014, 16'h00FE, 16'h00FF};
    pk_rsp = '{mtsp_pkg::RESP_SLVERR, mtsp_pkg::RESP_OKAY, mtsp_pkg::RESP_OKAY,
               mtsp_pkg::RESP_SLVERR};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Factory values
    rd(mtsp_pkg::IDX_COIL_TYPE, 32'h1, mtsp_pkg::RESP_OKAY);
    rd(mtsp_pkg::IDX_UV_P1, 32'h0, mtsp_pkg::RESP_OKAY);
    rd(mtsp_pkg::IDX_UV_P2, 32'h0, mtsp_pkg::RESP_OKAY);
    rd(mtsp_pkg::IDX_UV_P3, 32'h0, mtsp_pkg::RESP_OKAY);
    rd(mtsp_pkg::IDX_COIL_FACT, 32'h3D93_6A40, mtsp_pkg::RESP_OKAY);
    rd(mtsp_pkg::IDX_CT_P1, 32'h1, mtsp_pkg::RESP_OKAY);
    rd(mtsp_pkg::IDX_CT_P2, 32'h1, mtsp_pkg::RESP_OKAY);
    rd(mtsp_pkg::IDX_CT_P3, 32'h1, mtsp_pkg::RESP_OKAY);
    rd(mtsp_pkg::IDX_CT_N, 32'h1, mtsp_pkg::RESP_OKAY);
    rd(mtsp_pkg::IDX_PEAK_P1, 32'h14, mtsp_pkg::RESP_OKAY);
    chk_val({29'h0, uv_en}, 32'h0, "uv enable");
    chk_val(coil_eff, 32'h3D93_6A40, "coil factor");
    chk_val({ct_e1, ct_en}, 32'h0001_0001, "divisors");
    // Threshold bounds: 1.0 and 440.0 accepted, just outside refused
    wr(mtsp_pkg::IDX_UV_P1, 32'h3F80_0000, mtsp_pkg::RESP_OKAY);
    wr(mtsp_pkg::IDX_UV_P2, 32'h43DC_0000, mtsp_pkg::RESP_OKAY);
    wr(mtsp_pkg::IDX_UV_P3, 32'h43DC_0001, mtsp_pkg::RESP_SLVERR);
    wr(mtsp_pkg::IDX_UV_P3, 32'h3F7F_FFFF, mtsp_pkg::RESP_SLVERR);
    rd(mtsp_pkg::IDX_UV_P3, 32'h0, mtsp_pkg::RESP_OKAY);
    chk_val({29'h0, uv_en}, 32'h3, "uv enable");
    chk_val(uv_p2, 32'h43DC_0000, "uv phase2");
    wr(mtsp_pkg::IDX_UV_P1, 32'h0, mtsp_pkg::RESP_OKAY);
    chk_val({29'h0, uv_en}, 32'h2, "uv enable");
    chk_val(uv_p1 | uv_p3, 32'h0, "uv p1 p3");
    // Coil selector table, then user-defined factor
    for (int s = 1; s < 4; s++)
    begin
      wr(mtsp_pkg::IDX_COIL_TYPE, s, mtsp_pkg::RESP_OKAY);
      chk_val(coil_eff, coil_tab[s], "coil table");
    end
    wr(mtsp_pkg::IDX_COIL_FACT, 32'h3E00_0000, mtsp_pkg::RESP_OKAY);
    wr(mtsp_pkg::IDX_COIL_TYPE, 32'h0, mtsp_pkg::RESP_OKAY);
    chk_val(coil_eff, 32'h3E00_0000, "user coil");
    wr(mtsp_pkg::IDX_COIL_FACT, 32'h0, mtsp_pkg::RESP_SLVERR);
    wr(mtsp_pkg::IDX_COIL_FACT, 32'hBE00_0000, mtsp_pkg::RESP_SLVERR);
    chk_val(coil_eff, 32'h3E00_0000, "user coil kept");
    wr(mtsp_pkg::IDX_COIL_TYPE, 32'h4, mtsp_pkg::RESP_SLVERR);
    rd(mtsp_pkg::IDX_COIL_TYPE, 32'h0, mtsp_pkg::RESP_OKAY);
    // Divisor limits and the scaling enables
    wr(mtsp_pkg::IDX_CT_P1, 32'h9C4, mtsp_pkg::RESP_OKAY);
    wr(mtsp_pkg::IDX_CT_P1, 32'h9C5, mtsp_pkg::RESP_SLVERR);
    wr(mtsp_pkg::IDX_CT_P2, 32'h0, mtsp_pkg::RESP_SLVERR);
    wr(mtsp_pkg::IDX_CT_P3, 32'h1_0005, mtsp_pkg::RESP_SLVERR);
    wr(mtsp_pkg::IDX_CT_N, 32'hFFFF, mtsp_pkg::RESP_OKAY);
    rd(mtsp_pkg::IDX_CT_P1, 32'h9C4, mtsp_pkg::RESP_OKAY);
    chk_val({ct_e1, ct_en}, 32'h0001_0001, "unscaled");
    wr(mtsp_pkg::IDX_SCALE_CTRL, 32'h9000, mtsp_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_val({ct_e1, ct_en}, 32'h09C4_FFFF, "scaled");
    chk_val({ct_e2, ct_e3}, 32'h0001_0001, "scale off");
    wr(mtsp_pkg::IDX_SCALE_CTRL, 32'h0, mtsp_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_val({ct_e1, ct_en}, 32'h0001_0001, "unity again");
    // Peak interval edges: 19 and 255 refused
    pk_keep = 16'h0014;
    for (int i = 0; i < 4; i++)
    begin
      wr(mtsp_pkg::IDX_PEAK_P1, {16'h0, pk_val[i]}, pk_rsp[i]);
      if (pk_rsp[i] === mtsp_pkg::RESP_OKAY) pk_keep = pk_val[i];
      rd(mtsp_pkg::IDX_PEAK_P1, {16'h0, pk_keep}, mtsp_pkg::RESP_OKAY);
      chk_val({16'h0, peak}, {16'h0, pk_keep}, "peak out");
    end
    // Status: last write refused, user coil, only phase 2 check on
    rd(mtsp_pkg::IDX_STATUS, 32'h1A, mtsp_pkg::RESP_OKAY);
    wr(mtsp_pkg::IDX_STATUS, 32'h0, mtsp_pkg::RESP_SLVERR);
    rd(mtsp_pkg::IDX_STATUS, 32'h1A, mtsp_pkg::RESP_OKAY);
    // Unmapped place
    wr(10'h3FF, 32'h1, mtsp_pkg::RESP_DECERR);
    rd(10'h3FF, 32'h0, mtsp_pkg::RESP_DECERR);
    end_of_test();
  end
endmodule
